// ---- include/port_e_pkg.sv ----
// constants and types for the port e pin assignment block
// Behaviour
// RULE1 - free-cycle enable low drives pin 7
// RULE2 - four enables: once normal, never emulation, anytime special
// RULE3 - free-cycle, queue, rw ignored single-chip/peripheral
// RULE4 - queue enable high drives pins 6:5
// RULE5 - clock disable writable except emulation modes
// RULE6 - clock disable low drives E clock pin 4
// RULE7 - E clock output possible in every mode
// RULE8 - low-strobe enable high drives pin 3
// RULE9 - tagging: sample tag rising, strobe falling
// RULE10 - low-strobe ignored single-chip, peripheral, normal narrow
// RULE11 - low strobe disabled after normal expanded reset
// RULE12 - reads never depend on low strobe
// RULE13 - rw enable high drives pin 2
// RULE14 - rw output disabled after normal expanded reset
// RULE15 - alternate function overrides direction bit
// RULE16 - test/emulation reset selects bus control pins
// RULE17 - write-once accepts first write only
package port_e_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ASSIGN_ADDR = 4'h0;
    localparam logic [3:0] WLOCK_ADDR  = 4'h4;
    localparam logic [3:0] MODE_ADDR   = 4'h8;
    localparam logic [7:0] ASSIGN_MASK = 8'hbc;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FREE_BIT  = 7;
    localparam int QUEUE_BIT = 5;
    localparam int CLKD_BIT  = 4;
    localparam int LSTR_BIT  = 3;
    localparam int RW_BIT    = 2;

    // ------------------------------------------------------------
    // mode codes (c,b,a)
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_SPEC_SC   = 3'h0;
    localparam logic [2:0] MODE_EMU_NAR   = 3'h1;
    localparam logic [2:0] MODE_SPEC_TEST = 3'h2;
    localparam logic [2:0] MODE_EMU_WIDE  = 3'h3;
    localparam logic [2:0] MODE_NORM_SC   = 3'h4;
    localparam logic [2:0] MODE_NORM_NAR  = 3'h5;
    localparam logic [2:0] MODE_PERIPH    = 3'h6;
    localparam logic [2:0] MODE_NORM_WIDE = 3'h7;

    // ------------------------------------------------------------
    // reset values per mode
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TEST   = 8'h2c;
    localparam logic [7:0] RST_EMU    = 8'hac;
    localparam logic [7:0] RST_NORMSC = 8'h10;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {WR_ONCE, WR_NEVER, WR_ANY} wr_policy_t;
endpackage

// ---- logic/port_e_function_assign.sv ----
// port e pin function assignment with axi4-lite register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module port_e_function_assign (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [2:0]  opMode,
    // ------------------------------------------------------------
    // bus control sources and port pins
    // ------------------------------------------------------------
    input  wire logic        cpuFreeCycle,
    input  wire logic        queueStatusHi,
    input  wire logic        queueStatusLo,
    input  wire logic        busClockE,
    input  wire logic        lowByteStrobe,
    input  wire logic        readWrite,
    input  wire logic        backgroundDebugTag,
    input  wire logic        tagLowInput,
    input  wire logic [7:2]  directionRegE,
    input  wire logic [7:2]  portDataE,
    output logic [7:2]       pinOut,
    output logic [7:2]       pinOe,
    output logic [7:2]       altSelect,
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    function automatic port_e_pkg::wr_policy_t policyOf(input logic [2:0] m);
        if (m == port_e_pkg::MODE_PERIPH) begin
            // peripheral mode counts as a special mode
            policyOf = port_e_pkg::WR_ANY;
        end else if (m[0] == 1'b1 && m[2] == 1'b0) begin
            policyOf = port_e_pkg::WR_NEVER;
        end else if (m[2] == 1'b0) begin
            policyOf = port_e_pkg::WR_ANY;
        end else begin
            policyOf = port_e_pkg::WR_ONCE;
        end
    endfunction

    function automatic logic busModeOf(input logic [2:0] m);
        busModeOf = !(m == port_e_pkg::MODE_SPEC_SC || m == port_e_pkg::MODE_NORM_SC
                      || m == port_e_pkg::MODE_PERIPH);
    endfunction

    function automatic logic [7:0] resetValOf(input logic [2:0] m);
        case (m)
            port_e_pkg::MODE_SPEC_TEST: resetValOf = port_e_pkg::RST_TEST;
            port_e_pkg::MODE_EMU_NAR:   resetValOf = port_e_pkg::RST_EMU;
            port_e_pkg::MODE_EMU_WIDE:  resetValOf = port_e_pkg::RST_EMU;
            port_e_pkg::MODE_NORM_SC:   resetValOf = port_e_pkg::RST_NORMSC;
            default:                    resetValOf = port_e_pkg::RST_ZERO;
        endcase
    endfunction

    // ------------------------------------------------------------
    // register select
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SEL_ASSIGN, SEL_LOCK, SEL_MODE, SEL_NONE} reg_sel_t;

    function automatic reg_sel_t regSelOf(input logic [3:0] a);
        case (a)
            port_e_pkg::ASSIGN_ADDR: regSelOf = SEL_ASSIGN;
            port_e_pkg::WLOCK_ADDR:  regSelOf = SEL_LOCK;
            port_e_pkg::MODE_ADDR:   regSelOf = SEL_MODE;
            default:                 regSelOf = SEL_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // assignment register and its write-once locks
        logic       loaded;
        logic [7:0] assign_bits;
        logic [7:0] locked;
        // write channel
        logic       awHeld;
        logic [3:0] awAddr;
        logic       wHeld;
        logic [7:0] wData;
        logic       wLane0;
        logic       bValid;
        logic [1:0] bResp;
        // read channel
        logic       rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        // pin side
        logic       eClkPrev;
        logic [7:2] pinOut;
    } state_t;

    state_t st_reg;
    state_t st_next;

    port_e_pkg::wr_policy_t policy;
    logic       busMode;
    logic       narrowNormal;
    logic [7:0] eff;
    logic       doWrite;
    logic [7:0] writable;
    logic       eClkRise;
    logic       eClkFall;
    logic       strobeOut;
    reg_sel_t   wrSel;
    reg_sel_t   rdSel;

    assign policy       = policyOf(opMode);
    assign busMode      = busModeOf(opMode);
    assign narrowNormal = (opMode == port_e_pkg::MODE_NORM_NAR);
    assign eClkRise     = busClockE && !st_reg.eClkPrev;
    assign eClkFall     = !busClockE && st_reg.eClkPrev;
    assign doWrite      = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
    assign wrSel        = regSelOf(st_reg.awAddr);
    assign rdSel        = regSelOf(s_axi_araddr);

    // ------------------------------------------------------------
    // effective selection per pin
    // ------------------------------------------------------------
    // bit 4 is never gated: the bus clock is wanted in every mode
    always_comb begin
        eff = 8'h00;
        eff[7] = busMode && !st_reg.assign_bits[port_e_pkg::FREE_BIT]; // RULE1 RULE3
        eff[6] = busMode && st_reg.assign_bits[port_e_pkg::QUEUE_BIT]; // RULE4 RULE3
        eff[5] = eff[6];                                               // RULE4
        eff[4] = !st_reg.assign_bits[port_e_pkg::CLKD_BIT];            // RULE6 RULE7
        eff[3] = busMode && !narrowNormal
                 && st_reg.assign_bits[port_e_pkg::LSTR_BIT];          // RULE8 RULE10
        eff[2] = busMode && st_reg.assign_bits[port_e_pkg::RW_BIT];    // RULE13 RULE3
    end

    // retimes the low-byte strobe around the E clock while tagging
    strobe_stage u_strobe (
        .clk           (clk),
        .nrst          (nrst),
        .tagEn         (backgroundDebugTag),
        .eClkRise      (eClkRise),
        .eClkFall      (eClkFall),
        .tagLowInput   (tagLowInput),
        .lowByteStrobe (lowByteStrobe),
        .strobeOut     (strobeOut)
    );

    // ------------------------------------------------------------
    // write permission per bit
    // ------------------------------------------------------------
    // clock disable keeps its own rule, the other enables follow the mode class
    always_comb begin
        writable = 8'h00;
        for (int i = 2; i < 8; i++) begin
            if (port_e_pkg::ASSIGN_MASK[i]) begin
                if (i == port_e_pkg::CLKD_BIT) begin
                    writable[i] = (policy != port_e_pkg::WR_NEVER); // RULE5
                end else begin
                    case (policy)
                        port_e_pkg::WR_ANY:  writable[i] = 1'b1;             // RULE2
                        port_e_pkg::WR_ONCE: writable[i] = !st_reg.locked[i]; // RULE2 RULE17
                        default:             writable[i] = 1'b0;             // RULE2
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.eClkPrev = busClockE;
        // ------------------------------------------------------------
        // mode reset value
        // ------------------------------------------------------------
        // opMode is read on the first edge after release, so it must be settled by then
        if (!st_reg.loaded) begin
            st_next.loaded      = 1'b1;
            st_next.assign_bits = resetValOf(opMode); // RULE11 RULE14 RULE16
        end

        // ------------------------------------------------------------
        // write channel
        // ------------------------------------------------------------
        if (s_axi_awvalid && !st_reg.awHeld) begin
            st_next.awHeld = 1'b1;
            st_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.wHeld) begin
            st_next.wHeld  = 1'b1;
            st_next.wData  = s_axi_wdata[7:0];
            st_next.wLane0 = s_axi_wstrb[0];
        end
        if (doWrite) begin
            st_next.awHeld = 1'b0;
            st_next.wHeld  = 1'b0;
            st_next.bValid = 1'b1;
            st_next.bResp  = port_e_pkg::RESP_OKAY;
            // any accepted assignment write with lane 0 strobed takes the lock, even one that changes nothing
            if (wrSel == SEL_ASSIGN) begin
                if (st_reg.wLane0 && st_reg.loaded) begin
                    for (int i = 2; i < 8; i++) begin
                        if (writable[i]) begin
                            st_next.assign_bits[i] = st_reg.wData[i];
                        end
                        if (port_e_pkg::ASSIGN_MASK[i]) begin
                            st_next.locked[i] = 1'b1; // RULE17
                        end
                    end
                end
            end else if (wrSel == SEL_NONE) begin
                st_next.bResp = port_e_pkg::RESP_SLVERR;
            end
        end
        if (st_reg.bValid && s_axi_bready) begin
            st_next.bValid = 1'b0;
        end

        // ------------------------------------------------------------
        // read channel
        // ------------------------------------------------------------
        if (s_axi_arvalid && !st_reg.rValid) begin
            st_next.rValid = 1'b1;
            st_next.rResp  = port_e_pkg::RESP_OKAY;
            case (rdSel)
                SEL_ASSIGN:
                    st_next.rData = {24'h000000, st_reg.assign_bits & port_e_pkg::ASSIGN_MASK};
                SEL_LOCK:
                    st_next.rData = {24'h000000, st_reg.locked};
                SEL_MODE:
                    st_next.rData = {29'h00000000, opMode};
                default: begin
                    st_next.rData = 32'h00000000;
                    st_next.rResp = port_e_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.rValid && s_axi_rready) begin
            st_next.rValid = 1'b0;
        end

        // ------------------------------------------------------------
        // pin drive: alternate function overrides the port data bit
        // ------------------------------------------------------------
        for (int p = 2; p < 8; p++) begin
            st_next.pinOut[p] = portDataE[p];
        end
        if (eff[7]) st_next.pinOut[7] = cpuFreeCycle;   // RULE1
        if (eff[6]) st_next.pinOut[6] = queueStatusHi;  // RULE4
        if (eff[5]) st_next.pinOut[5] = queueStatusLo;  // RULE4
        if (eff[4]) st_next.pinOut[4] = busClockE;      // RULE6
        if (eff[3]) st_next.pinOut[3] = strobeOut;      // RULE8 RULE12
        if (eff[2]) st_next.pinOut[2] = readWrite;      // RULE13
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 2; p < 8; p++) begin
            pinOe[p] = eff[p] ? 1'b1 : directionRegE[p]; // RULE15
        end
    end

    assign pinOut        = st_reg.pinOut;
    assign altSelect     = eff[7:2];

    // ------------------------------------------------------------
    // register bus outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !st_reg.awHeld;
    assign s_axi_wready  = !st_reg.wHeld;
    assign s_axi_bvalid  = st_reg.bValid;
    assign s_axi_bresp   = st_reg.bResp;
    assign s_axi_arready = !st_reg.rValid;
    assign s_axi_rvalid  = st_reg.rValid;
    assign s_axi_rdata   = st_reg.rData;
    assign s_axi_rresp   = st_reg.rResp;
endmodule

// ---- logic/strobe_stage.sv ----
// low-byte strobe stage timed by the E clock
`timescale 1ns/1ps
module strobe_stage (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic tagEn,
    input  wire logic eClkRise,
    input  wire logic eClkFall,
    input  wire logic tagLowInput,
    input  wire logic lowByteStrobe,
    output logic      strobeOut
);
    typedef struct packed {
        logic out;
    } st_t;
    st_t st_reg;
    st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (!tagEn) begin
            st_next.out = lowByteStrobe;
        end else begin
            if (eClkRise) begin
                st_next.out = tagLowInput; // RULE9
            end
            if (eClkFall) begin
                st_next.out = lowByteStrobe; // RULE9
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign strobeOut = st_reg.out;
endmodule

// ---- verification/ext_bus_model.sv ----
// external bus side: resolves port e pin levels
`timescale 1ns/1ps
module ext_bus_model (
    input  wire logic [7:2] pinOut,
    input  wire logic [7:2] pinOe,
    output logic      [7:2] pinLevel
);
    // undriven pins, such as strobe and rw left as io, sit at the pull-up level
    assign pinLevel = (pinOut & pinOe) | ~pinOe;
endmodule

// ---- verification/port_e_assertions.sv ----
// concurrent checks on the port e pin assignment block ports
`timescale 1ns/1ps
module port_e_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [2:0]  opMode,
    input wire logic        cpuFreeCycle,
    input wire logic        queueStatusHi,
    input wire logic        queueStatusLo,
    input wire logic        busClockE,
    input wire logic        readWrite,
    input wire logic [7:2]  directionRegE,
    input wire logic [7:2]  pinOut,
    input wire logic [7:2]  pinOe,
    input wire logic [7:2]  altSelect,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    pin_oe_alt_a: assert property (pinOe == (altSelect | directionRegE))
        else $error("pin enable wrong");
    bus_gate_a: assert property (opMode inside {3'h0, 3'h4, 3'h6}
        |-> {altSelect[7:5], altSelect[2]} == 4'h0) else $error("gate");
    strobe_gate_a: assert property (opMode inside {3'h0, 3'h4, 3'h5, 3'h6} |-> !altSelect[3])
        else $error("strobe gate wrong");
    free_pin_a: assert property ($past(nrst) && $past(altSelect[7])
        |-> pinOut[7] == $past(cpuFreeCycle)) else $error("free cycle pin wrong");
    queue_pins_a: assert property ($past(nrst) && $past(altSelect[5])
        |-> pinOut[6:5] == {$past(queueStatusHi), $past(queueStatusLo)}) else $error("queue");
    clock_pin_a: assert property ($past(nrst) && $past(altSelect[4])
        |-> pinOut[4] == $past(busClockE)) else $error("clock pin wrong");
    rw_pin_a: assert property ($past(nrst) && $past(altSelect[2])
        |-> pinOut[2] == $past(readWrite)) else $error("rw pin wrong");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (altSelect[3] && altSelect[7]);
    cover property (!altSelect[4] && pinOe[4]);
endmodule
bind port_e_function_assign port_e_checker checker_i (
    .clk(clk), .nrst(nrst), .opMode(opMode), .cpuFreeCycle(cpuFreeCycle),
    .queueStatusHi(queueStatusHi), .queueStatusLo(queueStatusLo), .busClockE(busClockE),
    .readWrite(readWrite), .directionRegE(directionRegE), .pinOut(pinOut), .pinOe(pinOe),
    .altSelect(altSelect), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ---- verification/tb_top.sv ----
// self-checking bench for the port e pin assignment block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, cpuFreeCycle = 1'b0, queueStatusHi = 1'b0;
    logic queueStatusLo = 1'b0, busClockE = 1'b0, lowByteStrobe = 1'b0, readWrite = 1'b0;
    logic backgroundDebugTag = 1'b0, tagLowInput = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [2:0]  opMode = 3'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [7:2]  directionRegE = 6'h00, portDataE = 6'h00, pinOut, pinOe, altSelect, pinLevel;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fail_count = 0, total_checks = 0;
    logic [7:0]  rstv [8] = '{8'h00, 8'hac, 8'h2c, 8'hac, 8'h10, 8'h00, 8'h00, 8'h00};
    always #4 clk = ~clk;
    port_e_function_assign dut (.clk(clk), .nrst(nrst), .opMode(opMode),
        .cpuFreeCycle(cpuFreeCycle), .queueStatusHi(queueStatusHi), .queueStatusLo(queueStatusLo),
        .busClockE(busClockE), .lowByteStrobe(lowByteStrobe), .readWrite(readWrite),
        .backgroundDebugTag(backgroundDebugTag), .tagLowInput(tagLowInput),
        .directionRegE(directionRegE), .portDataE(portDataE), .pinOut(pinOut), .pinOe(pinOe),
        .altSelect(altSelect), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    ext_bus_model bus_i (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));
    task automatic report_and_stop;
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) begin
            chk("write answer", 32'h1, 32'h0);
            report_and_stop();
        end
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) begin
            chk("read answer", 32'h1, 32'h0);
            report_and_stop();
        end
    endtask
    task automatic do_reset(input logic [2:0] m);
        nrst <= 1'b0;
        opMode <= m;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [7:2] exp_alt(input logic [7:0] v, input logic [2:0] m);
        logic g, s;
        g = m inside {3'h0, 3'h4, 3'h6};
        s = g || m == 3'h5;
        return {~v[7] & ~g, {2{v[5] & ~g}}, ~v[4], v[3] & ~s, v[2] & ~g};
    endfunction
    task automatic look(input logic [2:0] m, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(4'h0, d, r);
        chk("assign reg", {24'h0, e}, d);
        chk("alt select", 32'(exp_alt(e, m)), 32'(altSelect));
    endtask
    // reset value, mode readback, write policy and gating in every mode
    task automatic mode_sweep;
        logic [7:0] e;
        logic [31:0] d;
        logic [1:0] r;
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            e = rstv[m];
            look(3'(m), e);
            axi_rd(4'h8, d, r);
            chk("mode reg", 32'(m), d);
            axi_wr(4'h0, 8'h69, r);
            if (!(m inside {1, 3})) e = 8'h28;
            look(3'(m), e);
            axi_wr(4'h0, 8'hd6, r);
            if (m inside {0, 2, 6}) e = 8'h94;
            else if (m > 3) e = 8'h38;
            look(3'(m), e);
        end
    endtask
    // bus control routing, tag timing, gpio fallback and unmapped access
    task automatic pin_route;
        logic [31:0] d;
        logic [1:0] r;
        do_reset(3'h2);
        {cpuFreeCycle, queueStatusHi, queueStatusLo, busClockE, lowByteStrobe, readWrite} <= 6'h2f;
        repeat (3) @(posedge clk);
        chk("bus pins", 32'h2f, 32'(pinOut));
        chk("bus oe", 32'h3f, 32'(pinOe));
        backgroundDebugTag <= 1'b1;
        tagLowInput <= 1'b1;
        lowByteStrobe <= 1'b0;
        busClockE <= 1'b0;
        repeat (3) @(posedge clk);
        busClockE <= 1'b1;
        repeat (3) @(posedge clk);
        chk("tag phase", 32'h1, 32'(pinOut[3]));
        busClockE <= 1'b0;
        repeat (3) @(posedge clk);
        chk("strobe phase", 32'h0, 32'(pinOut[3]));
        axi_wr(4'h0, 8'h90, r);
        portDataE <= 6'h2a;
        directionRegE <= 6'h0f;
        repeat (3) @(posedge clk);
        chk("gpio oe", 32'h0f, 32'(pinOe));
        chk("gpio level", 32'h3a, 32'(pinLevel));
        axi_wr(4'hc, 8'hff, r);
        chk("unmapped wr resp", 32'h2, 32'(r));
        axi_rd(4'hc, d, r);
        chk("unmapped rd resp", 32'h2, 32'(r));
        chk("unmapped rd data", 32'h0, d);
    endtask
    initial begin
        mode_sweep();
        pin_route();
        report_and_stop();
    end
endmodule
